/* verilog/dlpsc_top.sv */
// module: low-power state control of an lpddr3 dram die
// ----------------------------------------------------------------
// How it works
// - cke low with cs_n high on an edge enters power-down; inputs ignored
// - cke low, cs_n low, ca0 ca1 high, ca2 low enters deep power-down
// - deep power-down entry marks array contents lost
// - cke high exits deep power-down; full init needed before normal use
// - cs_n high during change with cke high; ready after 2tCK plus tXP; a change is not seen here, only power-down exit waits 2tCK plus tXP
// - cs_n high during stop with cke high; ready after 2tCK plus tXP; a clock stop is not seen here, only power-down exit waits 2tCK plus tXP
// - nop decodes as cs_n high, or cs_n low with ca0..ca2 high
// - nop never terminates an operation already in progress
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module dlpsc_top (
  // clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          reset_n,
  // command pins from the controller
  input  wire logic                          ckePin,
  input  wire logic                          csNPin,
  input  wire logic [dlpsc_pkg::CA_WIDTH-1:0] caPin,
  // initialisation sequence finished, from the init engine
  input  wire logic                          initDone,
  // power state
  output logic                               powerDown,
  output logic                               deepPowerDown,
  // readiness after exit or initialisation
  output logic                               initRequired,
  output logic                               dataLost,
  output logic                               readyNormal,
  // command observation
  output logic                               nopSeen,
  output logic                               inputsGated
);
  dlpsc_cmd_if cmd ();

  dlpsc_pin_sync u_sync (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .ckePin  (ckePin),
    .csNPin  (csNPin),
    .caPin   (caPin),
    .cmd     (cmd)
  );

  dlpsc_pkg::dlpsc_state_type state;
  dlpsc_pkg::dlpsc_state_type next_state;
  logic [dlpsc_pkg::CNT_WIDTH-1:0] count;
  logic [dlpsc_pkg::CNT_WIDTH-1:0] next_count;
  logic next_powerDown;
  logic next_deepPowerDown;
  logic next_initRequired;
  logic next_dataLost;
  logic next_readyNormal;
  logic next_nopSeen;
  logic next_inputsGated;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  logic isDpdCmd;
  logic isNop;
  logic ckeSteady;

  assign isDpdCmd = !cmd.csN
                    && cmd.ca[dlpsc_pkg::CA0_POS]
                    && cmd.ca[dlpsc_pkg::CA1_POS]
                    && !cmd.ca[dlpsc_pkg::CA2_POS];
  // deselect is a nop whatever ca carries
  assign isNop = cmd.csN
                 || (cmd.ca[dlpsc_pkg::CA0_POS]
                     && cmd.ca[dlpsc_pkg::CA1_POS]
                     && cmd.ca[dlpsc_pkg::CA2_POS]);
  // a nop is only meaningful with a steady cke level
  assign ckeSteady = (cmd.cke == cmd.ckePrev);

  // ----------------------------------------------------------------
  // power state machine
  // ----------------------------------------------------------------
  // spacing of entry after refresh, activate or mode register access is
  // the controller's to keep; the die only sees the cke edge, so a late
  // burst is not caught here
  always_comb begin
    next_state         = state;
    next_deepPowerDown = deepPowerDown;
    next_initRequired  = initRequired;
    next_dataLost      = dataLost;
    next_readyNormal   = readyNormal;
    next_powerDown     = 1'b0;
    next_inputsGated   = 1'b0;
    case (state)
      dlpsc_pkg::ST_ACTIVE: begin
        next_readyNormal = !initRequired;
        // entry needs cke seen high one sample earlier: a cke held low
        // through reset enters nothing until it has been raised once
        if (!cmd.cke && cmd.ckePrev) begin
          if (isDpdCmd) begin
            next_state         = dlpsc_pkg::ST_DEEP_PD;
            next_deepPowerDown = 1'b1;
            next_dataLost      = 1'b1;
            next_initRequired  = 1'b1;
            next_readyNormal   = 1'b0;
            next_inputsGated   = 1'b1;
          end else if (cmd.csN) begin
            next_state       = dlpsc_pkg::ST_PWR_DOWN;
            next_powerDown   = 1'b1;
            next_readyNormal = 1'b0;
            next_inputsGated = 1'b1;
          end
        end
      end
      dlpsc_pkg::ST_PWR_DOWN: begin
        // everything but cke is a don't-care while down
        next_powerDown   = 1'b1;
        next_inputsGated = 1'b1;
        if (cmd.cke) begin
          next_state     = dlpsc_pkg::ST_EXIT_WAIT;
          next_powerDown = 1'b0;
        end
      end
      dlpsc_pkg::ST_DEEP_PD: begin
        // clock may be stopped here; exit sampled only on cke rise
        next_inputsGated = 1'b1;
        if (cmd.cke) begin
          next_state         = dlpsc_pkg::ST_INIT;
          next_deepPowerDown = 1'b0;
          next_inputsGated   = 1'b0;
        end
      end
      dlpsc_pkg::ST_INIT: begin
        // held off normal use until the full init sequence is done
        if (initDone) begin
          next_state        = dlpsc_pkg::ST_ACTIVE;
          next_initRequired = 1'b0;
          next_dataLost     = 1'b0;
          next_readyNormal  = 1'b1;
        end
      end
      dlpsc_pkg::ST_EXIT_WAIT: begin
        // exit latency: two clocks plus tXP before commands count
        if (count >= dlpsc_pkg::CNT_WIDTH'(dlpsc_pkg::STABLE_CLK_CYCLES
                     + dlpsc_pkg::TXP_CYCLES - 1)) begin
          // one clock only: a frequency change cannot be seen here
          next_state       = dlpsc_pkg::ST_ACTIVE;
          next_readyNormal = !initRequired;
        end
      end
      default: begin
        next_state = dlpsc_pkg::ST_ACTIVE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state and output registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state         <= dlpsc_pkg::ST_ACTIVE;
      powerDown     <= 1'b0;
      deepPowerDown <= 1'b0;
      initRequired  <= 1'b0;
      dataLost      <= 1'b0;
      readyNormal   <= 1'b1;
      inputsGated   <= 1'b0;
    end else begin
      state         <= next_state;
      powerDown     <= next_powerDown;
      deepPowerDown <= next_deepPowerDown;
      initRequired  <= next_initRequired;
      dataLost      <= next_dataLost;
      readyNormal   <= next_readyNormal;
      inputsGated   <= next_inputsGated;
    end
  end

  // ----------------------------------------------------------------
  // exit latency counter
  // ----------------------------------------------------------------
  // counts only while waiting out an exit, so every exit starts at zero
  always_comb begin
    next_count = '0;
    if (state == dlpsc_pkg::ST_EXIT_WAIT) begin
      next_count = count + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // ----------------------------------------------------------------
  // nop tracking
  // ----------------------------------------------------------------
  // a nop only raises a flag: running operations are left alone
  always_comb begin
    next_nopSeen = isNop && ckeSteady;
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      nopSeen <= 1'b0;
    end else begin
      nopSeen <= next_nopSeen;
    end
  end
endmodule
`default_nettype wire

/* verilog/dlpsc_pkg.sv */
// package: constants and types for the dram low-power state control block
package dlpsc_pkg;

  // command bus widths
  localparam int CA_WIDTH = 10;

  // ca bit positions used in decode
  localparam int CA0_POS = 0;
  localparam int CA1_POS = 1;
  localparam int CA2_POS = 2;

  // timing figures (ns) and derived cycle counts at 100 MHz
  localparam int CLK_PERIOD_NS = 10;
  localparam int TXP_NS = 8;
  localparam int TXP_CYCLES =
    (TXP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STABLE_CLK_CYCLES = 2;
  localparam int INIT_CYCLES = 8;
  localparam int CNT_WIDTH = 8;

  // power state machine, one-hot
  typedef enum logic [4:0] {
    ST_ACTIVE    = 5'h01,
    ST_PWR_DOWN  = 5'h02,
    ST_DEEP_PD   = 5'h04,
    ST_INIT      = 5'h08,
    ST_EXIT_WAIT = 5'h10
  } dlpsc_state_type;

endpackage

/* verilog/dlpsc_cmd_if.sv */
// interface: sampled pin values passed from pin stage to the state control
`timescale 1ns/1ps
`default_nettype none
interface dlpsc_cmd_if;
  logic                          cke;
  logic                          ckePrev;
  logic                          csN;
  logic [dlpsc_pkg::CA_WIDTH-1:0] ca;
  modport source (output cke, output ckePrev, output csN, output ca);
  modport sink   (input cke, input ckePrev, input csN, input ca);
endinterface
`default_nettype wire

/* verilog/dlpsc_pin_sync.sv */
// module: three-stage pin synchroniser for cke, cs_n and ca
`timescale 1ns/1ps
`default_nettype none
module dlpsc_pin_sync (
  // clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          reset_n,
  // raw pins
  input  wire logic                          ckePin,
  input  wire logic                          csNPin,
  input  wire logic [dlpsc_pkg::CA_WIDTH-1:0] caPin,
  // synchronised values
  dlpsc_cmd_if.source                         cmd
);
  localparam int W = dlpsc_pkg::CA_WIDTH + 2;

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  logic [W-1:0] held;
  logic [W-1:0] next_held;
  logic         prevCke;
  logic         next_prevCke;

  // ----------------------------------------------------------------
  // accept cke once stage two and three agree
  // ----------------------------------------------------------------
  // only cke is filtered: it is a level held for many cycles, while
  // cs_n and ca carry one-cycle commands that a filter would swallow;
  // both leave stage three together, so they stay aligned
  always_comb begin
    next_held = stage3;
    if (stage2[W-1] != stage3[W-1]) begin
      next_held[W-1] = held[W-1];
    end
    next_prevCke = held[W-1];
  end

  // reset values: cke low, cs_n high (idle)
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      stage1  <= {2'h1, {dlpsc_pkg::CA_WIDTH{1'b1}}};
      stage2  <= {2'h1, {dlpsc_pkg::CA_WIDTH{1'b1}}};
      stage3  <= {2'h1, {dlpsc_pkg::CA_WIDTH{1'b1}}};
      held    <= {2'h1, {dlpsc_pkg::CA_WIDTH{1'b1}}};
      prevCke <= 1'b0;
    end else begin
      stage1  <= {ckePin, csNPin, caPin};
      stage2  <= stage1;
      stage3  <= stage2;
      held    <= next_held;
      prevCke <= next_prevCke;
    end
  end

  assign cmd.cke     = held[W-1];
  assign cmd.csN     = held[W-2];
  assign cmd.ca      = held[dlpsc_pkg::CA_WIDTH-1:0];
  assign cmd.ckePrev = prevCke;
endmodule
`default_nettype wire

/* testbench/dlpsc_asserts.sv */
// checker: port-level properties of the low-power state control
`timescale 1ns/1ps
`default_nettype none
module dlpsc_asserts (
  // clock and reset
  input wire logic                           ref_clk,
  input wire logic                           reset_n,
  // command pins and init handshake
  input wire logic                           ckePin,
  input wire logic                           csNPin,
  input wire logic [dlpsc_pkg::CA_WIDTH-1:0] caPin,
  input wire logic                           initDone,
  // state outputs
  input wire logic                           powerDown,
  input wire logic                           deepPowerDown,
  input wire logic                           initRequired,
  input wire logic                           dataLost,
  input wire logic                           readyNormal,
  input wire logic                           nopSeen,
  input wire logic                           inputsGated
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // windows of 7 cover the 5-edge pin-to-state latency with margin
  sequence s_pdCmd;
    ckePin && readyNormal ##1 (!ckePin && csNPin)[*7];
  endsequence
  sequence s_dpdCmd;
    ckePin && readyNormal ##1 !ckePin && !csNPin && caPin[2:0] == 3'h3
    ##1 (!ckePin)[*6];
  endsequence
  sequence s_wake;
    deepPowerDown && $rose(ckePin) ##1 ckePin[*6];
  endsequence
  property p_pdEntry;
    s_pdCmd |-> powerDown && !readyNormal;
  endproperty
  a_pdEntry: assert property (p_pdEntry) else $error("no power-down");
  property p_gated;
    powerDown || deepPowerDown |-> inputsGated && !readyNormal;
  endproperty
  a_gated: assert property (p_gated) else $error("inputs not gated");
  property p_dpdEntry;
    s_dpdCmd |-> deepPowerDown && !powerDown;
  endproperty
  a_dpdEntry: assert property (p_dpdEntry) else $error("no deep pd");
  property p_lost;
    $rose(deepPowerDown) |-> dataLost && initRequired;
  endproperty
  a_lost: assert property (p_lost) else $error("data not lost");
  property p_dpdExit;
    s_wake |-> !deepPowerDown && !readyNormal;
  endproperty
  a_dpdExit: assert property (p_dpdExit) else $error("bad dpd exit");
  property p_initHold;
    initRequired && !initDone |=> initRequired && !readyNormal;
  endproperty
  a_initHold: assert property (p_initHold) else $error("init skipped");
  property p_initDone;
    initRequired && !deepPowerDown && initDone |=> readyNormal && !dataLost;
  endproperty
  a_initDone: assert property (p_initDone) else $error("not ready");
  property p_pdExit;
    $fell(powerDown) |-> !readyNormal[*3] ##1 readyNormal;
  endproperty
  a_pdExit: assert property (p_pdExit) else $error("exit latency");
  property p_nopCs;
    (ckePin && csNPin && readyNormal)[*8] |-> nopSeen;
  endproperty
  a_nopCs: assert property (p_nopCs) else $error("nop missed");
  property p_nopCa;
    (ckePin && !csNPin && caPin[2:0] == 3'h7 && readyNormal)[*8] |-> nopSeen;
  endproperty
  a_nopCa: assert property (p_nopCa) else $error("ca nop missed");
endmodule
bind dlpsc_top dlpsc_asserts i_dlpsc_asserts (.ref_clk, .reset_n, .ckePin,
  .csNPin, .caPin, .initDone, .powerDown, .deepPowerDown, .initRequired,
  .dataLost, .readyNormal, .nopSeen, .inputsGated);
`default_nettype wire

/* testbench/dlpsc_ctrl_model.sv */
// partner: memory controller driving cke, chip select and command bus
`timescale 1ns/1ps
`default_nettype none
module dlpsc_ctrl_model (
  // clock
  input  wire logic                          ref_clk,
  // command pins
  output var logic                           ckePin,
  output var logic                           csNPin,
  output var logic [dlpsc_pkg::CA_WIDTH-1:0] caPin
);
  initial begin
    ckePin = 1'b1;
    csNPin = 1'b1;
    caPin  = 10'h000;
  end
  // clock never stops or changes here
  // only nops precede entry, so nothing is in flight
  task automatic drive(input logic cke, input logic csN, input logic [2:0] ca);
    @(posedge ref_clk);
    ckePin <= cke;
    csNPin <= csN;
    // deselected ca is don't-care: flip it so stale values cannot pass
    caPin  <= csN ? ~caPin : {7'h00, ca};
  endtask
endmodule
`default_nettype wire

/* testbench/dlpsc_top_bench.sv */
// testbench: scenarios for the low-power state control
`timescale 1ns/1ps
`default_nettype none
module dlpsc_top_bench;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic initDone = 1'b0;
  logic ckePin, csNPin, powerDown, deepPowerDown, initRequired;
  logic dataLost, readyNormal, nopSeen, inputsGated;
  logic [dlpsc_pkg::CA_WIDTH-1:0] caPin;
  int failures = 0;
  int checked = 0;
  always #5 ref_clk = ~ref_clk;
  dlpsc_ctrl_model i_dlpsc_ctrl_model (.ref_clk, .ckePin, .csNPin, .caPin);
  dlpsc_top i_dlpsc_top (.ref_clk, .reset_n, .ckePin, .csNPin, .caPin,
    .initDone, .powerDown, .deepPowerDown, .initRequired, .dataLost,
    .readyNormal, .nopSeen, .inputsGated);
  task automatic chk(input logic got, input logic exp, input string msg);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic pins(input logic c, input logic s, input logic [2:0] a);
    i_dlpsc_ctrl_model.drive(c, s, a);
  endtask
  // reset is synchronous and clears every stage: two edges suffice
  task automatic do_reset();
    @(posedge ref_clk) reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    cyc(6);
    chk(readyNormal, 1'b1, "not ready after reset");
  endtask
  task automatic t_nop();
    pins(1'b1, 1'b1, 3'h0);
    cyc(8);
    chk(nopSeen, 1'b1, "deselect nop");
    pins(1'b1, 1'b0, 3'h7);
    cyc(8);
    chk(nopSeen, 1'b1, "ca nop");
    pins(1'b1, 1'b0, 3'h1);
    cyc(8);
    chk(nopSeen, 1'b0, "command taken as nop");
    pins(1'b1, 1'b1, 3'h0);
    cyc(8);
    $display("test nop done");
  endtask
  task automatic t_pd();
    pins(1'b0, 1'b1, 3'h0);
    cyc(8);
    chk(powerDown, 1'b1, "no power-down");
    chk(inputsGated, 1'b1, "inputs live");
    pins(1'b0, 1'b0, 3'h3);
    cyc(8);
    chk(deepPowerDown, 1'b0, "gated input obeyed");
    pins(1'b1, 1'b1, 3'h0);
    cyc(6);
    chk(powerDown, 1'b0, "no exit");
    chk(readyNormal, 1'b0, "ready too early");
    cyc(3);
    chk(readyNormal, 1'b1, "not ready after exit");
    $display("test power-down done");
  endtask
  task automatic t_refused();
    pins(1'b0, 1'b0, 3'h0);
    pins(1'b0, 1'b1, 3'h0);
    cyc(8);
    chk(powerDown || deepPowerDown, 1'b0, "bad entry taken");
    pins(1'b1, 1'b1, 3'h0);
    cyc(8);
    $display("test refused done");
  endtask
  task automatic t_dpd();
    pins(1'b0, 1'b0, 3'h3);
    pins(1'b0, 1'b1, 3'h0);
    cyc(8);
    chk(deepPowerDown, 1'b1, "no deep pd");
    chk(dataLost, 1'b1, "contents kept");
    pins(1'b1, 1'b1, 3'h0);
    cyc(8);
    chk(deepPowerDown, 1'b0, "no wake");
    chk(initRequired, 1'b1, "init dropped");
    chk(readyNormal, 1'b0, "ready before init");
    pins(1'b1, 1'b0, 3'h7);
    cyc(8);
    chk(nopSeen, 1'b1, "nop during init missed");
    chk(initRequired, 1'b1, "nop ended init");
    chk(readyNormal, 1'b0, "nop made ready");
    pins(1'b1, 1'b1, 3'h0);
    @(posedge ref_clk) initDone <= 1'b1;
    cyc(2);
    chk(readyNormal, 1'b1, "not ready after init");
    chk(dataLost, 1'b0, "lost flag stuck");
    @(posedge ref_clk) initDone <= 1'b0;
    $display("test deep power-down done");
  endtask
  // reset in mid-run while deep power-down holds cke low
  task automatic t_midreset();
    pins(1'b0, 1'b0, 3'h3);
    pins(1'b0, 1'b1, 3'h0);
    cyc(8);
    chk(deepPowerDown, 1'b1, "no second deep pd");
    do_reset();
    chk(deepPowerDown, 1'b0, "state kept over reset");
    chk(initRequired, 1'b0, "init flag kept over reset");
    chk(dataLost, 1'b0, "lost flag kept over reset");
    chk(powerDown, 1'b0, "false entry after reset");
    $display("test mid-run reset done");
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #20000;
    failures++;
    print_verdict();
  end
  initial begin
    do_reset();
    t_nop();
    t_pd();
    t_refused();
    t_dpd();
    t_midreset();
    print_verdict();
  end
endmodule
`default_nettype wire
